// >>> bench/boot_image_loader_chk.sv
`timescale 1ns/10ps
module boot_image_loader_chk
  import boot_pkg::*;
#(
  parameter int unsigned RESET_PERIOD = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] core_clock_ratio,
  input wire logic gpio_pull_enable,
  input wire logic spi_select_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_out_en,
  input wire logic link_out_wire_a,
  input wire logic link_out_wire_b,
  input wire logic link_out_en,
  input wire logic link_pull_down_en,
  input wire logic chan_end0_busy,
  input wire logic otp_rd,
  input wire logic [10:0] otp_addr,
  input wire logic ram_we,
  input wire logic [13:0] ram_addr,
  input wire logic ram_ready,
  input wire logic run_enable,
  input wire logic [13:0] exec_address,
  input wire logic boot_failed
);
  int unsigned up_cnt;
  logic [13:0] wr_cnt;
  logic otp_seen;
  // Edges since release, saturating
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) up_cnt <= 0;
    else if (up_cnt < RESET_PERIOD + 8) up_cnt <= up_cnt + 1;
  // Accepted RAM writes, the expected next address
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) wr_cnt <= 14'h0000;
    else if (ram_we && ram_ready) wr_cnt <= wr_cnt + 14'h0001;
  // First OTP read seen
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) otp_seen <= 1'b0;
    else if (otp_rd) otp_seen <= 1'b1;

  default clocking dclk @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Reset itself is the antecedent here, so no disable
  property p_hiz;
    disable iff (1'b0) !reset_n |-> !spi_out_en && !link_out_en;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pins driven in reset");
  property p_pull_early;
    up_cnt + 2 < RESET_PERIOD |-> !gpio_pull_enable;
  endproperty
  a_pull_early: assert property (p_pull_early)
    else $error("pulls on early");
  property p_pull_late;
    up_cnt > RESET_PERIOD + 2 |-> gpio_pull_enable;
  endproperty
  a_pull_late: assert property (p_pull_late)
    else $error("pulls off late");
  property p_ratio_hold;
    gpio_pull_enable |-> $stable(core_clock_ratio);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold)
    else $error("clock ratio moved after boot");
  property p_sclk_idle;
    spi_select_n |-> !spi_sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock not idle low");
  property p_sclk_high;
    $rose(spi_sclk) |=> spi_sclk ##1 !spi_sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high phase wrong");
  property p_mosi_hold;
    spi_sclk && $past(spi_sclk) |-> $stable(spi_mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data out moved while clock high");
  property p_link_start;
    $rose(link_out_en) |-> !link_out_wire_a && !link_out_wire_b
      && !link_pull_down_en;
  endproperty
  a_link_start: assert property (p_link_start)
    else $error("bad link start");
  property p_ram_order;
    ram_we |-> ram_addr == RAM_BASE + wr_cnt;
  endproperty
  a_ram_order: assert property (p_ram_order)
    else $error("RAM write out of order");
  property p_run_clean;
    run_enable |-> !boot_failed && exec_address == RAM_BASE && !ram_we
      && !chan_end0_busy;
  endproperty
  a_run_clean: assert property (p_run_clean)
    else $error("bad run state");
  property p_otp_first;
    otp_rd && !otp_seen |-> otp_addr == 11'h000;
  endproperty
  a_otp_first: assert property (p_otp_first)
    else $error("OTP start not zero");
  c_run: cover property ($rose(run_enable));
  c_fail: cover property ($rose(boot_failed));
  c_link: cover property ($rose(link_out_en));
endmodule
// boot_image_loader_chk

bind boot_image_loader boot_image_loader_chk #(
  .RESET_PERIOD(RESET_PERIOD)
) i_chk (.*);

// >>> bench/boot_image_loader_tb_top.sv
`timescale 1ns/10ps
module boot_image_loader_tb_top;
  import boot_pkg::*;
  localparam int unsigned PERIOD = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b1;
  logic clock_ratio_select_lo = 1'b0;
  logic clock_ratio_select_hi = 1'b0;
  logic [1:0] boot_source_select = 2'h0;
  logic [31:0] security_bits = 32'h00000000;
  logic link_in_wire_a = 1'b0;
  logic link_in_wire_b = 1'b0;
  logic otp_rvalid = 1'b0;
  logic [31:0] otp_rdata = 32'h00000000;
  logic ram_ready = 1'b1;
  logic spi_miso, spi_select_n, spi_sclk, spi_mosi, spi_out_en;
  logic gpio_pull_enable, link_out_wire_a, link_out_wire_b, link_out_en;
  logic link_pull_down_en, chan_end0_busy, otp_rd, ram_we, run_enable;
  logic boot_failed, prev_a, prev_b;
  logic [1:0] core_clock_ratio;
  logic [10:0] otp_addr;
  logic [13:0] ram_addr, exec_address;
  logic [31:0] ram_wdata;
  logic [31:0] ram [0:63];
  logic [31:0] otp_mem [0:63];
  logic [7:0] img [$];
  logic reply [$];
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  boot_image_loader #(.RESET_PERIOD(PERIOD)) i_dut (.*);
  spi_flash_model i_flash (
    .select_n(spi_select_n), .sclk(spi_sclk), .mosi(spi_mosi),
    .miso(spi_miso)
  );

  initial forever #50 ref_clk = ~ref_clk;
  // RAM takes a word when both sides agree
  always @(posedge ref_clk)
    if (ram_we === 1'b1 && ram_ready) ram[ram_addr[5:0]] <= ram_wdata;
  // OTP answers one cycle late; idle data is inverted, not stale
  always @(negedge ref_clk)
  begin
    otp_rvalid <= otp_rd;
    otp_rdata <= otp_rd ? otp_mem[otp_addr[5:0]] : ~otp_rdata;
  end
  // Outgoing link toggles, b is a one
  always @(negedge ref_clk)
  begin
    if (link_out_en === 1'b1 && link_out_wire_a !== prev_a) reply.push_back(0);
    if (link_out_en === 1'b1 && link_out_wire_b !== prev_b) reply.push_back(1);
    prev_a <= link_out_wire_a;
    prev_b <= link_out_wire_b;
  end
  // Hang guard, well above test length
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] prog_word(input int i);
    return 32'h9E3779B9 * 32'(i + 1);
  endfunction

  function automatic logic [31:0] crc_next(input logic [31:0] c,
    input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction

  // Kind 0 good check word, 1 corrupted, 2 skip marker
  task automatic build(input int n, input int kind);
    logic [31:0] c;
    logic [31:0] w;
    c = 32'hFFFFFFFF;
    img.delete();
    for (int i = -1; i < n; i++)
    begin
      w = (i < 0) ? 32'(n) : prog_word(i);
      for (int k = 0; k < 4; k++)
      begin
        img.push_back(w[8*k +: 8]);
        c = crc_next(c, w[8*k +: 8]);
      end
    end
    c = ~c;
    w = (kind == 2) ? 32'h0D15AB1E : (kind == 1) ? c ^ 32'h00000100 : c;
    for (int k = 0; k < 4; k++) img.push_back(w[8*k +: 8]);
  endtask

  task automatic start(input logic [1:0] src, input logic [31:0] sec,
    input logic [1:0] ratio);
    @(negedge ref_clk);
    reset_n = 1'b0;
    boot_source_select = src;
    security_bits = sec;
    {clock_ratio_select_hi, clock_ratio_select_lo} = ratio;
    link_in_wire_a = 1'b0;
    link_in_wire_b = 1'b0;
    ram_ready = 1'b1;
    foreach (ram[i]) ram[i] = 32'h00000000;
    repeat (12) @(negedge ref_clk);
    check("pins in reset", {spi_out_en, link_out_en, gpio_pull_enable}, 0);
    reset_n = 1'b1;
    repeat (PERIOD + 4) @(negedge ref_clk);
    check("pull enable", gpio_pull_enable, 1'b1);
    check("clock ratio", core_clock_ratio, ratio);
  endtask

  task automatic finish_boot(input int n, input logic ok);
    for (int t = 0; t < 20000 && run_enable !== 1'b1 && boot_failed !== 1'b1;
      t++) @(negedge ref_clk);
    check("run", run_enable, ok);
    check("failed", boot_failed, !ok);
    check("entry", exec_address, 14'h0000);
    for (int i = 0; i < n && ok; i++) check("ram", ram[i], prog_word(i));
  endtask

  // RAM stalled: sclk must stop on full buffer
  task automatic test_spi_good;
    logic s;
    build(40, 0);
    foreach (img[i]) i_flash.mem[i] = img[i];
    start(2'h2, 32'h00000000, 2'h2);
    check("spi pins", {spi_select_n, spi_out_en, link_out_en}, 3'h2);
    ram_ready = 1'b0;
    repeat (5000) @(negedge ref_clk);
    s = 1'b0;
    repeat (40) @(negedge ref_clk) s = s | spi_sclk;
    check("sclk stalled", s, 1'b0);
    ram_ready = 1'b1;
    finish_boot(40, 1'b1);
    check("command", i_flash.cmd, {SPI_READ_CMD, 24'h000000});
  endtask

  task automatic test_spi(input logic [1:0] src, input int n, input int kind);
    build(n, kind);
    foreach (img[i]) i_flash.mem[i] = img[i];
    start(src, 32'h00000000, 2'h1);
    finish_boot(n, kind != 1);
    check("select released", spi_select_n, 1'b1);
  endtask

  // Security bit beats link select
  task automatic test_otp;
    build(4, 2);
    for (int j = 0; j < 6; j++)
      otp_mem[j] = {img[4*j+3], img[4*j+2], img[4*j+1], img[4*j]};
    start(2'h1, 32'h00000020, 2'h3);
    check("link pins", link_out_en, 1'b0);
    finish_boot(4, 1'b1);
  endtask

  task automatic send_sym(input logic b);
    if (b) link_in_wire_b = ~link_in_wire_b;
    else link_in_wire_a = ~link_in_wire_a;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic send_token(input logic ctrl, input logic [7:0] d);
    send_sym(ctrl);
    for (int k = 0; k < 8; k++) send_sym(d[k]);
  endtask

  task automatic test_link(input logic [31:0] ack);
    logic [8:0] got;
    logic quiet;
    quiet = ack[15:0] == 16'hFF02;
    build(3, 0);
    start(2'h1, 32'h00000000, 2'h0);
    check("link start", {link_out_en, link_out_wire_a, link_out_wire_b,
      link_pull_down_en, spi_out_en}, 5'h10);
    reply.delete();
    for (int k = 0; k < 4; k++) send_token(1'b0, ack[8*k +: 8]);
    check("channel end", chan_end0_busy, 1'b1);
    foreach (img[i]) send_token(1'b0, img[i]);
    send_token(1'b1, END_TOKEN);
    finish_boot(3, 1'b1);
    repeat (80) @(negedge ref_clk);
    got = 9'h000;
    foreach (reply[k]) got[k] = reply[k];
    check("reply size", reply.size(), quiet ? 0 : 9);
    check("reply", got, quiet ? 9'h000 : {END_TOKEN, 1'b1});
    check("channel freed", chan_end0_busy, 1'b0);
  endtask

  initial
  begin
    #1 reset_n = 1'b0;
    test_spi_good();
    test_spi(2'h0, 0, 2);
    test_spi(2'h3, 3, 1);
    test_otp();
    test_link(32'h00010005);
    test_link(32'h0000FF02);
    tally_and_finish();
  end
endmodule
// boot_image_loader_tb_top

// >>> bench/spi_flash_model.sv
`timescale 1ns/10ps
module spi_flash_model (
  input wire logic select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:255];
  logic [31:0] cmd;
  int rises = 0;
  initial miso = 1'b0;
  // Rising edges since select fell
  always @(posedge sclk or posedge select_n)
    rises <= select_n ? 0 : rises + 1;
  // Command and address shift in MSB first, mode zero
  always @(posedge sclk)
    if (rises < 32) cmd <= {cmd[30:0], mosi};
  // Bytes LSB first on falling edges; released line shows no stale bit
  always @(negedge sclk or posedge select_n)
    if (select_n) miso <= ~miso;
    else if (rises >= 32) miso <= mem[(rises - 32) / 8][(rises - 32) % 8];
endmodule
// spi_flash_model

// >>> hdl/boot_image_loader.sv
`timescale 1ns/10ps
module word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_valid && out_ready)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // word_fifo

module boot_image_loader
  import boot_pkg::*;
#(
  parameter int unsigned RESET_PERIOD = RESET_PERIOD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clock_ratio_select_lo,
  input wire logic clock_ratio_select_hi,
  input wire logic [1:0] boot_source_select,
  input wire logic [31:0] security_bits,
  output logic [1:0] core_clock_ratio,
  output logic gpio_pull_enable,
  input wire logic spi_miso,
  output logic spi_select_n,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic spi_out_en,
  input wire logic link_in_wire_a,
  input wire logic link_in_wire_b,
  output logic link_out_wire_a,
  output logic link_out_wire_b,
  output logic link_out_en,
  output logic link_pull_down_en,
  output logic chan_end0_busy,
  output logic otp_rd,
  output logic [10:0] otp_addr,
  input wire logic otp_rvalid,
  input wire logic [31:0] otp_rdata,
  output logic ram_we,
  output logic [13:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic ram_ready,
  output logic run_enable,
  output logic [13:0] exec_address,
  output logic boot_failed
);
  // One byte through the reflected CRC register
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  state_e state;
  state_e next_state;
  src_e src;
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic [19:0] rst_cnt;
  logic [1:0] link_dly;
  logic fetch_on;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [1:0] byte_cnt;
  logic [23:0] word_sh;
  logic [31:0] word_val;
  logic got_word;
  logic [31:0] words_left;
  logic [31:0] crc;
  logic [31:0] ack_word;
  logic crc_ok;
  logic overrun;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;

  // Pins cross into ref_clk through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end
    else
    begin
      pin_meta <= {clock_ratio_select_hi, clock_ratio_select_lo,
                   boot_source_select, spi_miso, link_in_wire_b,
                   link_in_wire_a};
      pin_sync <= pin_meta;
    end
  end

  assign word_val = {byte_data, word_sh};
  assign got_word = byte_valid && byte_cnt == 2'h3;
  assign fetch_on = next_state == ST_GET_LEN ||
                    next_state == ST_GET_PROG || next_state == ST_GET_CRC;

  // Link token receiver signals
  logic [1:0] link_prev;
  logic [1:0] link_edge;
  logic [8:0] rx_sh;
  logic [3:0] rx_cnt;
  logic link_byte_valid;
  logic [7:0] link_byte;
  logic end_seen;
  logic link_enabled;
  // SPI engine signals
  logic [31:0] cmd_sr;
  logic [5:0] cmd_left;
  logic [2:0] spi_bitn;
  logic [7:0] spi_rx;
  logic [1:0] spi_div;
  logic spi_byte_valid;
  logic spi_go;
  logic spi_hold;
  // OTP reader signals
  logic [31:0] otp_buf;
  logic [2:0] otp_left;
  logic otp_pending;
  logic otp_byte_valid;
  logic [7:0] otp_byte;
  // Link transmitter signals
  logic [8:0] tx_sh;
  logic [3:0] tx_cnt;
  logic [3:0] tx_gap;
  logic tx_done;

  // Boot sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      ST_WAIT_RST:
        if (rst_cnt == 20'(RESET_PERIOD - 1))
        begin
          if (security_bits[SECURE_BOOT_BIT])
            next_state = ST_GET_LEN;
          else if (pin_sync[4:3] == BOOT_SEL_LINK)
            next_state = ST_LINK_EN;
          else
            next_state = ST_GET_LEN;
        end
      ST_LINK_EN:
        if (link_dly == 2'(LINK_EN_CYCLES - 1))
          next_state = ST_GET_ACK;
      ST_GET_ACK:
        if (got_word)
          next_state = ST_GET_LEN;
      ST_GET_LEN:
        if (got_word)
          next_state = (word_val == 32'h0) ? ST_GET_CRC : ST_GET_PROG;
      ST_GET_PROG:
        if (got_word && words_left == 32'h1)
          next_state = ST_GET_CRC;
      ST_GET_CRC:
        if (got_word)
          next_state = (src == SRC_LINK) ? ST_LINK_END : ST_DRAIN;
      ST_LINK_END:
        if (end_seen)
          next_state = (ack_word[15:0] == ACK_NULL_LOW) ? ST_DRAIN
                                                         : ST_SEND_END;
      ST_SEND_END:
        if (tx_done)
          next_state = ST_DRAIN;
      ST_DRAIN:
        if (!fifo_out_valid && !ram_we)
          next_state = (crc_ok && !overrun) ? ST_RUN : ST_FAIL;
      ST_RUN: next_state = ST_RUN;
      ST_FAIL: next_state = ST_FAIL;
      default: next_state = ST_FAIL;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_WAIT_RST;
    else
      state <= next_state;
  end

  // Reset period, ratio capture and source choice
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_cnt <= 20'h00000;
      link_dly <= 2'h0;
      core_clock_ratio <= 2'h0;
      src <= SRC_SPI;
    end
    else if (state == ST_WAIT_RST)
    begin
      rst_cnt <= rst_cnt + 20'h00001;
      core_clock_ratio <= pin_sync[6:5];
      if (security_bits[SECURE_BOOT_BIT])
        src <= SRC_OTP;
      else if (pin_sync[4:3] == BOOT_SEL_LINK)
        src <= SRC_LINK;
      else
        src <= SRC_SPI;
    end
    else if (state == ST_LINK_EN)
      link_dly <= link_dly + 2'h1;
  end

  // Pin drivers stay off until boot starts
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gpio_pull_enable <= 1'b0;
      spi_out_en <= 1'b0;
      link_out_en <= 1'b0;
      link_pull_down_en <= 1'b0;
      link_enabled <= 1'b0;
      chan_end0_busy <= 1'b0;
      run_enable <= 1'b0;
      exec_address <= RAM_BASE;
      boot_failed <= 1'b0;
    end
    else
    begin
      gpio_pull_enable <= next_state != ST_WAIT_RST;
      spi_out_en <= next_state != ST_WAIT_RST && src == SRC_SPI;
      if (state == ST_LINK_EN && next_state == ST_GET_ACK)
        link_enabled <= 1'b1;
      link_out_en <= link_enabled;
      link_pull_down_en <= next_state != ST_WAIT_RST && !link_enabled;
      chan_end0_busy <= next_state == ST_GET_ACK ||
        (src == SRC_LINK && (fetch_on || next_state == ST_LINK_END ||
         next_state == ST_SEND_END));
      run_enable <= next_state == ST_RUN;
      if (next_state == ST_RUN)
        exec_address <= RAM_BASE;
      boot_failed <= next_state == ST_FAIL;
    end
  end

  // Byte stream from whichever source is active
  always_comb
  begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    case (src)
      SRC_SPI:
      begin
        byte_valid = spi_byte_valid;
        byte_data = spi_rx;
      end
      SRC_LINK:
      begin
        byte_valid = link_byte_valid;
        byte_data = link_byte;
      end
      SRC_OTP:
      begin
        byte_valid = otp_byte_valid;
        byte_data = otp_byte;
      end
      default:
      begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
      end
    endcase
  end

  // Word assembly, length count and CRC
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      byte_cnt <= 2'h0;
      word_sh <= 24'h000000;
      words_left <= 32'h0;
      crc <= CRC_PRESET;
      ack_word <= 32'h0;
      crc_ok <= 1'b0;
    end
    else if (byte_valid)
    begin
      byte_cnt <= byte_cnt + 2'h1;
      word_sh <= {byte_data, word_sh[23:8]};
      if (state == ST_GET_LEN || state == ST_GET_PROG)
        crc <= crc_byte(crc, byte_data);
      if (got_word)
      begin
        if (state == ST_GET_ACK)
          ack_word <= word_val;
        if (state == ST_GET_LEN)
          words_left <= word_val;
        if (state == ST_GET_PROG)
          words_left <= words_left - 32'h1;
        if (state == ST_GET_CRC)
          crc_ok <= word_val == CRC_SKIP || word_val == ~crc;
      end
    end
  end

  // Program words enter the buffer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fifo_in_valid <= 1'b0;
      fifo_in_data <= 32'h0;
      overrun <= 1'b0;
    end
    else
    begin
      fifo_in_valid <= got_word && state == ST_GET_PROG;
      fifo_in_data <= word_val;
      // Link traffic cannot be paused, so a full buffer is fatal
      if (fifo_in_valid && !fifo_in_ready)
        overrun <= 1'b1;
    end
  end

  word_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) image_fifo (
    .clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // RAM write port, filled upward from the base
  assign fifo_out_ready = !ram_we || ram_ready;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ram_we <= 1'b0;
      ram_addr <= RAM_BASE;
      ram_wdata <= 32'h0;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      ram_we <= 1'b1;
      ram_wdata <= fifo_out_data;
      ram_addr <= ram_we ? ram_addr + 14'h0001 : ram_addr;
    end
    else if (ram_ready)
    begin
      ram_we <= 1'b0;
      if (ram_we)
        ram_addr <= ram_addr + 14'h0001;
    end
  end

  // SPI master, mode 0; data sampled at the falling edge
  // because the synchroniser delays MISO by two cycles
  assign spi_go = fetch_on && src == SRC_SPI;
  assign spi_hold = !spi_sclk && cmd_left == 6'h00 && spi_bitn == 3'h0 &&
                    !fifo_in_ready;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spi_select_n <= 1'b1;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
      cmd_sr <= 32'h0;
      cmd_left <= 6'h00;
      spi_bitn <= 3'h0;
      spi_rx <= 8'h00;
      spi_div <= 2'h0;
      spi_byte_valid <= 1'b0;
    end
    else
    begin
      spi_byte_valid <= 1'b0;
      if (spi_go && spi_select_n)
      begin
        spi_select_n <= 1'b0;
        spi_mosi <= SPI_READ_CMD[7];
        cmd_sr <= {SPI_READ_CMD[6:0], SPI_START_ADDR, 1'b0};
        cmd_left <= SPI_CMD_BITS;
        spi_div <= 2'h0;
      end
      else if (!spi_go)
      begin
        spi_select_n <= 1'b1;
        spi_sclk <= 1'b0;
      end
      else if (!spi_hold)
      begin
        if (spi_div == 2'(SPI_HALF_CYCLES - 1))
        begin
          spi_div <= 2'h0;
          spi_sclk <= !spi_sclk;
          if (spi_sclk && cmd_left != 6'h00)
          begin
            cmd_left <= cmd_left - 6'h01;
            spi_mosi <= cmd_sr[31];
            cmd_sr <= {cmd_sr[30:0], 1'b0};
          end
          else if (spi_sclk)
          begin
            spi_rx <= {pin_sync[2], spi_rx[7:1]};
            spi_bitn <= spi_bitn + 3'h1;
            spi_byte_valid <= spi_bitn == 3'h7;
          end
        end
        else
          spi_div <= spi_div + 2'h1;
      end
    end
  end

  // Link receive: a toggle on wire a is 0, on wire b is 1;
  // a token is a control flag then eight data bits
  assign link_edge = pin_sync[1:0] ^ link_prev;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_prev <= 2'h0;
      rx_sh <= 9'h000;
      rx_cnt <= 4'h0;
      link_byte_valid <= 1'b0;
      link_byte <= 8'h00;
      end_seen <= 1'b0;
    end
    else
    begin
      link_prev <= pin_sync[1:0];
      link_byte_valid <= 1'b0;
      end_seen <= 1'b0;
      if (link_enabled && link_edge != 2'h0)
      begin
        rx_sh <= {link_edge[1], rx_sh[8:1]};
        rx_cnt <= (rx_cnt == LINK_TOKEN_SYMS - 4'h1) ? 4'h0 : rx_cnt + 4'h1;
        if (rx_cnt == LINK_TOKEN_SYMS - 4'h1)
        begin
          link_byte <= {link_edge[1], rx_sh[8:2]};
          link_byte_valid <= !rx_sh[1] && fetch_on | (state == ST_GET_ACK);
          end_seen <= rx_sh[1] && {link_edge[1], rx_sh[8:2]} == END_TOKEN;
        end
      end
    end
  end

  // Link transmit of the closing end token
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_out_wire_a <= 1'b0;
      link_out_wire_b <= 1'b0;
      tx_sh <= 9'h000;
      tx_cnt <= 4'h0;
      tx_gap <= 4'h0;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (state == ST_LINK_END && next_state == ST_SEND_END)
      begin
        tx_sh <= {END_TOKEN, 1'b1};
        tx_cnt <= LINK_TOKEN_SYMS;
        tx_gap <= 4'h0;
      end
      else if (tx_cnt != 4'h0)
      begin
        tx_gap <= (tx_gap == LINK_TX_GAP - 4'h1) ? 4'h0 : tx_gap + 4'h1;
        if (tx_gap == 4'h0)
        begin
          if (tx_sh[0])
            link_out_wire_b <= !link_out_wire_b;
          else
            link_out_wire_a <= !link_out_wire_a;
          tx_sh <= {1'b0, tx_sh[8:1]};
          tx_cnt <= tx_cnt - 4'h1;
          tx_done <= tx_cnt == 4'h1;
        end
      end
    end
  end

  // OTP reader, whole words split into bytes LSB first
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      otp_rd <= 1'b0;
      otp_addr <= OTP_START_ADDR;
      otp_buf <= 32'h0;
      otp_left <= 3'h0;
      otp_pending <= 1'b0;
      otp_byte_valid <= 1'b0;
      otp_byte <= 8'h00;
    end
    else
    begin
      otp_rd <= 1'b0;
      otp_byte_valid <= 1'b0;
      if (otp_rd)
        otp_addr <= otp_addr + 11'h001;
      if (otp_rvalid && otp_pending)
      begin
        otp_buf <= otp_rdata;
        otp_left <= 3'h4;
        otp_pending <= 1'b0;
      end
      else if (otp_left != 3'h0)
      begin
        otp_byte_valid <= 1'b1;
        otp_byte <= otp_buf[7:0];
        otp_buf <= {8'h00, otp_buf[31:8]};
        otp_left <= otp_left - 3'h1;
      end
      else if (fetch_on && src == SRC_OTP && !otp_pending && !otp_rd &&
               fifo_in_ready)
      begin
        otp_rd <= 1'b1;
        otp_pending <= 1'b1;
      end
    end
  end
endmodule // boot_image_loader

// >>> hdl/boot_pkg.sv
package boot_pkg;
  // Clocking and timing
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned RESET_PERIOD_CYCLES = 750_000;
  localparam int unsigned SPI_SCLK_HZ = 2_500_000;
  localparam int unsigned SPI_HALF_CYCLES =
    (REF_CLK_HZ / (2 * SPI_SCLK_HZ) < 1) ? 1 :
    REF_CLK_HZ / (2 * SPI_SCLK_HZ);
  localparam int unsigned LINK_EN_DELAY_NS = 200;
  localparam int unsigned LINK_EN_CYCLES =
    (LINK_EN_DELAY_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] LINK_TX_GAP = 4'h8;
  localparam logic [3:0] LINK_TOKEN_SYMS = 4'h9;

  // Flash read sequence
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_START_ADDR = 24'h000000;
  localparam logic [5:0] SPI_CMD_BITS = 6'h20;

  // Image check
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [15:0] ACK_NULL_LOW = 16'hFF02;
  localparam logic [7:0] END_TOKEN = 8'h01;

  // Source selection and memory map
  localparam int unsigned SECURE_BOOT_BIT = 5;
  localparam logic [1:0] BOOT_SEL_LINK = 2'h1;
  localparam logic [10:0] OTP_START_ADDR = 11'h000;
  localparam logic [13:0] RAM_BASE = 14'h0000;
  localparam int unsigned FIFO_WIDTH = 32;
  localparam int unsigned FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    SRC_SPI = 3'b001,
    SRC_LINK = 3'b010,
    SRC_OTP = 3'b100
  } src_e;

  typedef enum logic [10:0] {
    ST_WAIT_RST = 11'b00000000001,
    ST_LINK_EN = 11'b00000000010,
    ST_GET_ACK = 11'b00000000100,
    ST_GET_LEN = 11'b00000001000,
    ST_GET_PROG = 11'b00000010000,
    ST_GET_CRC = 11'b00000100000,
    ST_LINK_END = 11'b00001000000,
    ST_SEND_END = 11'b00010000000,
    ST_DRAIN = 11'b00100000000,
    ST_RUN = 11'b01000000000,
    ST_FAIL = 11'b10000000000
  } state_e;
endpackage
